// ### design/t16ic_top.sv
`timescale 1ns/10ps
module t16ic_top
  import t16ic_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        capture_pin_i,
  input  wire logic        comparator_output_i,
  input  wire logic        external_tick_pin_i,
  input  wire logic        capture_irq_ack_i,
  input  wire logic        overflow_irq_ack_i,
  output logic             capture_irq_o,
  output logic             overflow_irq_o,
  output logic             timer_tick_o,
  output logic             top_o,
  output logic             bottom_o,
  output logic             count_down_o,
  output logic [3:0]       waveform_mode_field_o,
  output logic [15:0]      count_value_o,
  output logic [15:0]      compare_value_a_o,
  output logic [15:0]      compare_value_b_o
);
  t16ic_bus_st_t bus_st;
  t16ic_req_t    req;
  logic [7:0]    timer_control_a;
  logic [7:0]    timer_control_b;
  logic [7:0]    comparator_ctrl_status;
  logic [7:0]    irq_enable;
  logic [7:0]    high_latch;
  logic [15:0]   count_value;
  logic [15:0]   compare_value_a;
  logic [15:0]   compare_value_b;
  logic [15:0]   capture_value;
  logic          capture_flag;
  logic          overflow_flag;
  logic          count_down;
  logic [3:0]    mode;
  logic [2:0]    tick_source_select;
  logic          tick;
  logic [15:0]   top_value;
  logic          at_top;
  logic          at_bottom;
  logic          dual_slope;
  logic          single_top;
  logic          cap_is_top;
  logic          cap_src;
  logic          cap_event;
  logic          ovf_event;
  logic          wr_ev;
  logic          rd_ev;
  logic [7:0]    wdat;
  logic [7:0]    next_rdata;
  logic [15:0]   next_count;
  logic          next_down;
  t16ic_edge_t   ext_edge;
  t16ic_edge_t   cap_edge;

  // ---------------- AHB-Lite slave ----------------
  // writes complete with no wait state; reads take one wait state so the read data
  // and its latch side effect see every write that came before
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      bus_st <= T16IC_BUS_IDLE;
      req    <= '0;
    end else begin
      if (hreadyout) begin
        if (hsel && htrans[1]) begin
          req.offset <= haddr[7:0];
          req.write  <= hwrite;
          bus_st     <= hwrite ? T16IC_BUS_WR : T16IC_BUS_RD;
        end else begin
          bus_st <= T16IC_BUS_IDLE;
        end
      end else begin
        bus_st <= T16IC_BUS_IDLE;
      end
    end
  end

  assign hreadyout = (bus_st != T16IC_BUS_RD);
  assign hresp     = 1'b0;
  assign wr_ev     = (bus_st == T16IC_BUS_WR);
  assign rd_ev     = (bus_st == T16IC_BUS_RD);
  assign wdat      = hwdata[7:0];

  always_comb begin
    unique case (req.offset)
      OFS_CTRL_A:   next_rdata = timer_control_a;
      OFS_CTRL_B:   next_rdata = timer_control_b;
      OFS_CNT_L:    next_rdata = count_value[7:0];
      OFS_CNT_H:    next_rdata = high_latch;
      OFS_CMPA_L:   next_rdata = compare_value_a[7:0];
      OFS_CMPA_H:   next_rdata = compare_value_a[15:8];
      OFS_CMPB_L:   next_rdata = compare_value_b[7:0];
      OFS_CMPB_H:   next_rdata = compare_value_b[15:8];
      OFS_CAP_L:    next_rdata = capture_value[7:0];
      OFS_CAP_H:    next_rdata = high_latch;
      OFS_FLAGS:    next_rdata = {6'h00, overflow_flag, capture_flag};
      OFS_IRQ_EN:   next_rdata = irq_enable;
      OFS_COMP_CTL: next_rdata = comparator_ctrl_status;
      default:      next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i)
      hrdata <= 32'h00000000;
    else if (rd_ev)
      hrdata <= {24'h000000, next_rdata};
  end

  // ---------------- shared high-byte latch ----------------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      high_latch <= 8'h00;
    end else if (rd_ev && req.offset == OFS_CNT_L) begin
      high_latch <= count_value[15:8];
    end else if (rd_ev && req.offset == OFS_CAP_L) begin
      high_latch <= capture_value[15:8];
    end else if (wr_ev && (req.offset == OFS_CNT_H || req.offset == OFS_CMPA_H ||
                           req.offset == OFS_CMPB_H || req.offset == OFS_CAP_H)) begin
      high_latch <= wdat;
    end
  end

  // ---------------- control registers ----------------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      timer_control_a        <= CTRL_RST;
      timer_control_b        <= CTRL_RST;
      irq_enable             <= CTRL_RST;
      comparator_ctrl_status <= CTRL_RST;
    end else if (wr_ev) begin
      if (req.offset == OFS_CTRL_A)
        timer_control_a <= wdat;
      if (req.offset == OFS_CTRL_B)
        timer_control_b <= wdat;
      if (req.offset == OFS_IRQ_EN)
        irq_enable <= wdat;
      if (req.offset == OFS_COMP_CTL)
        comparator_ctrl_status <= wdat;
    end
  end

  assign mode = {timer_control_b[CB_MODE_LSB+1:CB_MODE_LSB],
                 timer_control_a[CA_MODE_LSB+1:CA_MODE_LSB]};
  assign tick_source_select = timer_control_b[CB_CS_LSB+2:CB_CS_LSB];

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      compare_value_a <= WORD_RST;
      compare_value_b <= WORD_RST;
    end else if (wr_ev) begin
      if (req.offset == OFS_CMPA_L)
        compare_value_a <= {high_latch, wdat};
      if (req.offset == OFS_CMPB_L)
        compare_value_b <= {high_latch, wdat};
    end
  end

  // ---------------- tick and mode decode ----------------
  t16ic_in_cond u_ext_cond (
    .clk_i     (clk_i),
    .srst_i    (srst_i),
    .din_i     (external_tick_pin_i),
    .filt_en_i (1'b0),
    .enable_i  (1'b1),
    .edge_o    (ext_edge)
  );

  t16ic_tick_sel u_tick (
    .clk_i                (clk_i),
    .srst_i               (srst_i),
    .tick_source_select_i (tick_source_select),
    .ext_edge_i           (ext_edge),
    .timer_tick_o         (tick)
  );

  // mode map: 0 normal, 1-3 dual 8/9/10 bit, 4 clear on compare A, 5-7 single 8/9/10 bit,
  // 8/10 dual to capture, 9/11 dual to compare A, 12 clear on capture, 13 counts as normal,
  // 14 single to capture, 15 single to compare A
  always_comb begin
    unique case (mode)
      4'h1, 4'h5:       top_value = TOP_8BIT;
      4'h2, 4'h6:       top_value = TOP_9BIT;
      4'h3, 4'h7:       top_value = TOP_10BIT;
      4'h4, 4'h9, 4'hB, 4'hF: top_value = compare_value_a;
      4'h8, 4'hA, 4'hC, 4'hE: top_value = capture_value;
      default:          top_value = CNT_MAX;
    endcase
  end

  assign dual_slope = (mode inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB});
  assign single_top = (mode inside {4'h5, 4'h6, 4'h7, 4'hE, 4'hF});
  assign cap_is_top = (mode inside {4'h8, 4'hA, 4'hC, 4'hE});
  assign at_top     = (count_value == top_value);
  assign at_bottom  = (count_value == WORD_RST);

  // ---------------- counter ----------------
  always_comb begin
    next_count = count_value;
    next_down  = count_down;
    ovf_event  = 1'b0;
    if (tick) begin
      if (dual_slope) begin
        if (!count_down && count_value >= top_value) begin
          next_down  = 1'b1;
          next_count = count_value - 16'h0001;
        end else if (count_down && at_bottom) begin
          next_down  = 1'b0;
          next_count = count_value + 16'h0001;
          ovf_event  = 1'b1;
        end else begin
          next_count = count_down ? count_value - 16'h0001 : count_value + 16'h0001;
        end
      end else begin
        next_down = 1'b0;
        // a written count above top runs on to max and wraps
        next_count = at_top ? WORD_RST : count_value + 16'h0001;
        ovf_event  = single_top ? at_top : (count_value == CNT_MAX);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      count_value <= WORD_RST;
      count_down  <= 1'b0;
    end else if (wr_ev && req.offset == OFS_CNT_L) begin
      count_value <= {high_latch, wdat};
    end else begin
      count_value <= next_count;
      count_down  <= next_down;
    end
  end

  // ---------------- capture unit ----------------
  // the source mux sits ahead of the synchroniser, so a source switch can look like an edge
  assign cap_src = comparator_ctrl_status[CC_SEL_BIT] ? comparator_output_i
                                                      : capture_pin_i;

  t16ic_in_cond u_cap_cond (
    .clk_i     (clk_i),
    .srst_i    (srst_i),
    .din_i     (cap_src),
    .filt_en_i (timer_control_b[CB_FILT_BIT]),
    .enable_i  (!cap_is_top),
    .edge_o    (cap_edge)
  );

  assign cap_event = timer_control_b[CB_EDGE_BIT] ? cap_edge.rise : cap_edge.fall;

  always_ff @(posedge clk_i) begin
    if (srst_i)
      capture_value <= WORD_RST;
    else if (cap_event)
      capture_value <= count_value;
    else if (wr_ev && req.offset == OFS_CAP_L && cap_is_top)
      capture_value <= {high_latch, wdat};
  end

  // set beats a same-cycle clear on both flags
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      capture_flag  <= 1'b0;
      overflow_flag <= 1'b0;
    end else begin
      if (cap_event)
        capture_flag <= 1'b1;
      else if (capture_irq_ack_i ||
               (wr_ev && req.offset == OFS_FLAGS && wdat[FL_CAP_BIT]))
        capture_flag <= 1'b0;
      if (ovf_event)
        overflow_flag <= 1'b1;
      else if (overflow_irq_ack_i ||
               (wr_ev && req.offset == OFS_FLAGS && wdat[FL_OVF_BIT]))
        overflow_flag <= 1'b0;
    end
  end

  assign capture_irq_o  = capture_flag & irq_enable[FL_CAP_BIT];
  assign overflow_irq_o = overflow_flag & irq_enable[FL_OVF_BIT];

  assign timer_tick_o          = tick;
  assign top_o                 = at_top;
  assign bottom_o              = at_bottom;
  assign count_down_o          = count_down;
  assign waveform_mode_field_o = mode;
  assign count_value_o         = count_value;
  assign compare_value_a_o     = compare_value_a;
  assign compare_value_b_o     = compare_value_b;
endmodule : t16ic_top

// ### common/t16ic_pkg.sv
package t16ic_pkg;

  localparam logic [7:0] OFS_CTRL_A   = 8'h00;
  localparam logic [7:0] OFS_CTRL_B   = 8'h04;
  localparam logic [7:0] OFS_CNT_L    = 8'h08;
  localparam logic [7:0] OFS_CNT_H    = 8'h0C;
  localparam logic [7:0] OFS_CMPA_L   = 8'h10;
  localparam logic [7:0] OFS_CMPA_H   = 8'h14;
  localparam logic [7:0] OFS_CMPB_L   = 8'h18;
  localparam logic [7:0] OFS_CMPB_H   = 8'h1C;
  localparam logic [7:0] OFS_CAP_L    = 8'h20;
  localparam logic [7:0] OFS_CAP_H    = 8'h24;
  localparam logic [7:0] OFS_FLAGS    = 8'h28;
  localparam logic [7:0] OFS_IRQ_EN   = 8'h2C;
  localparam logic [7:0] OFS_COMP_CTL = 8'h30;

  // control A: mode bits 1:0; control B: tick select 2:0, mode bits 4:3, edge 6, filter 7
  localparam int CA_MODE_LSB  = 0;
  localparam int CB_CS_LSB    = 0;
  localparam int CB_MODE_LSB  = 3;
  localparam int CB_EDGE_BIT  = 6;
  localparam int CB_FILT_BIT  = 7;
  localparam int FL_CAP_BIT   = 0;
  localparam int FL_OVF_BIT   = 1;
  localparam int CC_SEL_BIT   = 0;

  localparam logic [7:0]  CTRL_RST  = 8'h00;
  localparam logic [15:0] WORD_RST  = 16'h0000;
  localparam logic [15:0] CNT_MAX   = 16'hFFFF;
  localparam logic [15:0] TOP_8BIT  = 16'h00FF;
  localparam logic [15:0] TOP_9BIT  = 16'h01FF;
  localparam logic [15:0] TOP_10BIT = 16'h03FF;

  localparam logic [2:0] CS_STOP   = 3'h0;
  localparam logic [2:0] CS_DIV1   = 3'h1;
  localparam logic [2:0] CS_DIV8   = 3'h2;
  localparam logic [2:0] CS_DIV64  = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1K  = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  localparam int PRE_W   = 10;
  localparam int SH_8    = 3;
  localparam int SH_64   = 6;
  localparam int SH_256  = 8;
  localparam int FILT_N  = 4;

  typedef enum logic [1:0] {T16IC_BUS_IDLE, T16IC_BUS_WR, T16IC_BUS_RD} t16ic_bus_st_t;

  typedef struct packed {
    logic [7:0] offset;
    logic       write;
  } t16ic_req_t;

  typedef struct packed {
    logic rise;
    logic fall;
    logic level;
  } t16ic_edge_t;

endpackage : t16ic_pkg

// ### design/t16ic_in_cond.sv
`timescale 1ns/10ps
module t16ic_in_cond
  import t16ic_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  input  wire logic        din_i,
  input  wire logic        filt_en_i,
  input  wire logic        enable_i,
  output t16ic_edge_t      edge_o
);
  logic              s1;
  logic              s2;
  logic [FILT_N-2:0] hist;
  logic              filt;
  logic              prev;
  logic              cur;

  // two-flop synchroniser; s1 feeds only s2
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
    end else begin
      s1 <= din_i;
      s2 <= s1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      hist <= '0;
      filt <= 1'b0;
    end else begin
      // the live sample is the fourth vote, so the filter costs exactly four clocks
      hist <= {hist[FILT_N-3:0], s2};
      if (&{hist, s2})
        filt <= 1'b1;
      else if (~|{hist, s2})
        filt <= 1'b0;
    end
  end

  assign cur = filt_en_i ? filt : s2;

  always_ff @(posedge clk_i) begin
    if (srst_i)
      prev <= 1'b0;
    else
      prev <= cur;
  end

  always_comb begin
    edge_o.level = cur;
    edge_o.rise  = enable_i & cur & ~prev;
    edge_o.fall  = enable_i & ~cur & prev;
  end
endmodule : t16ic_in_cond

// ### design/t16ic_tick_sel.sv
`timescale 1ns/10ps
module t16ic_tick_sel
  import t16ic_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  input  wire logic [2:0]  tick_source_select_i,
  input  t16ic_edge_t      ext_edge_i,
  output logic             timer_tick_o
);
  logic [PRE_W-1:0] pre;

  // free-running prescaler; all taps share it so divided ticks stay phase aligned
  always_ff @(posedge clk_i) begin
    if (srst_i)
      pre <= '0;
    else
      pre <= pre + 1'b1;
  end

  always_comb begin
    unique case (tick_source_select_i)
      CS_STOP:     timer_tick_o = 1'b0;
      CS_DIV1:     timer_tick_o = 1'b1;
      CS_DIV8:     timer_tick_o = &pre[SH_8-1:0];
      CS_DIV64:    timer_tick_o = &pre[SH_64-1:0];
      CS_DIV256:   timer_tick_o = &pre[SH_256-1:0];
      CS_DIV1K:    timer_tick_o = &pre;
      CS_EXT_FALL: timer_tick_o = ext_edge_i.fall;
      CS_EXT_RISE: timer_tick_o = ext_edge_i.rise;
    endcase
  end
endmodule : t16ic_tick_sel

// ### tb/t16ic_top_checker.sv
`timescale 1ns/10ps
module t16ic_top_checker
  import t16ic_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [31:0] hwdata,
  input  wire logic        hreadyout,
  input  wire logic [31:0] hrdata,
  input  wire logic        timer_tick_o,
  input  wire logic        top_o,
  input  wire logic        bottom_o,
  input  wire logic [3:0]  waveform_mode_field_o,
  input  wire logic [15:0] count_value_o,
  input  wire logic [15:0] compare_value_a_o
);
  logic       dph_v;
  logic       dph_w;
  logic [7:0] dph_a;
  logic       wr_cnt;

  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);

  // data phase tracker: the address phase only counts once hreadyout lets it through
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      dph_v <= 1'b0;
    end else if (hreadyout) begin
      dph_v <= hsel & htrans[1];
      dph_w <= hwrite;
      dph_a <= haddr[7:0];
    end
  end

  assign wr_cnt = dph_v & dph_w & (dph_a == OFS_CNT_L);

  sequence s_rd_done(logic [7:0] ofs);
    dph_v && !dph_w && dph_a == ofs && hreadyout;
  endsequence

  sequence s_wr(logic [7:0] ofs);
    dph_v && dph_w && dph_a == ofs;
  endsequence

  a_stop_holds: assert property (
    !timer_tick_o && !wr_cnt |=> $stable(count_value_o))
    else $error("count moved without tick or write");
  a_tick_incr: assert property (
    waveform_mode_field_o == 4'h0 && timer_tick_o && !wr_cnt
    |=> count_value_o == $past(count_value_o) + 16'h0001)
    else $error("normal mode tick did not add one");
  a_write_wins: assert property (
    s_wr(OFS_CNT_L) |=> count_value_o[7:0] == $past(hwdata[7:0]))
    else $error("count write lost");
  a_bottom_zero: assert property (
    bottom_o == (count_value_o == 16'h0000))
    else $error("bottom flag wrong");
  a_top_normal: assert property (
    waveform_mode_field_o == 4'h0 |-> top_o == (count_value_o == 16'hFFFF))
    else $error("top flag wrong in normal mode");
  a_mode_split: assert property (
    s_wr(OFS_CTRL_A) |=> waveform_mode_field_o[1:0] == $past(hwdata[1:0]))
    else $error("mode low bits not taken");
  a_cmp_direct: assert property (
    s_rd_done(OFS_CMPA_H) |-> hrdata == {24'h0, compare_value_a_o[15:8]})
    else $error("compare high read not direct");
  a_cnt_lowrd: assert property (
    s_rd_done(OFS_CNT_L) |-> hrdata == {24'h0, $past(count_value_o[7:0])})
    else $error("count low read wrong");
endmodule : t16ic_top_checker

// ### tb/t16ic_host.sv
`timescale 1ns/10ps
module t16ic_host (
  input  wire logic        clk_i,
  input  wire logic        hreadyout,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata,
  output logic             hang_o
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    hang_o = 1'b0;
  end

  // resumes in the edge's active region, so hreadyout is the sampled value
  task automatic hs;
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (hreadyout !== 1'b1 && n < 64);
    if (n >= 64) hang_o <= 1'b1;
  endtask : hs

  task automatic addr_ph(input logic [7:0] a, input logic w);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    hs();
    htrans <= 2'h0;
  endtask : addr_ph

  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    addr_ph(a, 1'b1);
    hwdata <= {24'h0, d};
    hs();
  endtask : bus_wr

  task automatic bus_rd(input logic [7:0] a, output logic [7:0] d);
    addr_ph(a, 1'b0);
    hs();
    d = hrdata[7:0];
  endtask : bus_rd
endmodule : t16ic_host

// ### tb/t16ic_bench.sv
`timescale 1ns/10ps
module t16ic_bench
  import t16ic_pkg::*;
;
  logic clk_i, srst_i, hsel, hwrite, hready, hreadyout, hresp, hang_o;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic capture_pin_i, comparator_output_i, external_tick_pin_i;
  logic capture_irq_ack_i, overflow_irq_ack_i, capture_irq_o, overflow_irq_o;
  logic timer_tick_o, top_o, bottom_o, count_down_o;
  logic [3:0] waveform_mode_field_o;
  logic [15:0] count_value_o, compare_value_a_o, compare_value_b_o;
  int err_count = 0;
  int n_tests = 0;

  assign hready = hreadyout;
  t16ic_top u_dut (.*);
  t16ic_host u_host (.*);

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  task automatic tally_and_finish;
    if (err_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish

  always @(posedge hang_o) begin
    err_count++;
    tally_and_finish();
  end

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic chb(input logic g, input logic e);
    chk({15'h0, g}, {15'h0, e});
  endtask : chb

  task automatic tk(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tk

  task automatic w(input logic [7:0] a, input logic [7:0] d);
    u_host.bus_wr(a, d);
  endtask : w

  task automatic r(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    u_host.bus_rd(a, v);
    chk({8'h0, v}, {8'h0, e});
  endtask : r

  task automatic w16(input logic [7:0] a, input logic [15:0] v);
    w(a + 8'h04, v[15:8]);
    w(a, v[7:0]);
  endtask : w16

  task automatic r16(input logic [7:0] a, input logic [15:0] e);
    logic [7:0] lo;
    logic [7:0] hi;
    u_host.bus_rd(a, lo);
    u_host.bus_rd(a + 8'h04, hi);
    chk({hi, lo}, e);
  endtask : r16

  initial begin
    srst_i = 1'b1;
    capture_pin_i = 1'b0;
    comparator_output_i = 1'b0;
    external_tick_pin_i = 1'b0;
    capture_irq_ack_i = 1'b0;
    overflow_irq_ack_i = 1'b0;
    tk(10);
    srst_i <= 1'b0;
    chb(bottom_o, 1'b1);
    w(OFS_CMPA_H, 8'hAB);
    w(OFS_CMPA_L, 8'h56);
    w16(OFS_CNT_L, 16'h1234);
    w(OFS_CMPB_L, 8'h78);
    tk(1);
    chk(count_value_o, 16'h1234);
    chk(compare_value_a_o, 16'hAB56);
    chk(compare_value_b_o, 16'h1278);
    r(OFS_CNT_L, 8'h34);
    r(OFS_CMPA_H, 8'hAB);
    r(OFS_CNT_H, 8'h12);
    w(8'h3C, 8'h5A);
    r(8'h3C, 8'h00);
    w(OFS_CTRL_B, 8'h08);
    for (int i = 1; i < 4; i++) begin
      w(OFS_CTRL_A, 8'(i));
      w16(OFS_CNT_L, (16'h0100 << (i - 1)) - 16'h0001);
      tk(1);
      chk({12'h0, waveform_mode_field_o}, 16'h0004 + 16'(i));
      chb(top_o, 1'b1);
    end
    w(OFS_CTRL_A, 8'h00);
    w(OFS_CTRL_B, 8'h00);
    w16(OFS_CNT_L, 16'hFFFF);
    w(OFS_IRQ_EN, 8'h03);
    // two ticks land before the stop write takes effect
    w(OFS_CTRL_B, {5'h0, CS_DIV1});
    w(OFS_CTRL_B, 8'h00);
    tk(1);
    chk(count_value_o, 16'h0001);
    chb(overflow_irq_o, 1'b1);
    r(OFS_FLAGS, 8'h02);
    w(OFS_FLAGS, 8'h02);
    r(OFS_FLAGS, 8'h00);
    w(OFS_CTRL_B, {5'h0, CS_DIV1});
    w16(OFS_CNT_L, 16'h4000);
    w(OFS_CTRL_B, 8'h00);
    tk(1);
    chk(count_value_o, 16'h4002);
    w16(OFS_CNT_L, 16'h0000);
    w(OFS_CTRL_B, {5'h0, CS_EXT_RISE});
    repeat (3) begin
      external_tick_pin_i <= 1'b1;
      tk(4);
      external_tick_pin_i <= 1'b0;
      tk(4);
    end
    w(OFS_CTRL_B, 8'h00);
    tk(1);
    chk(count_value_o, 16'h0003);
    w(OFS_IRQ_EN, 8'h01);
    w(OFS_CTRL_B, 8'h40);
    capture_pin_i <= 1'b1;
    tk(8);
    chb(capture_irq_o, 1'b1);
    r16(OFS_CAP_L, 16'h0003);
    capture_irq_ack_i <= 1'b1;
    tk(1);
    capture_irq_ack_i <= 1'b0;
    tk(2);
    chb(capture_irq_o, 1'b0);
    capture_pin_i <= 1'b0;
    tk(8);
    chb(capture_irq_o, 1'b0);
    w16(OFS_CNT_L, 16'h0100);
    capture_pin_i <= 1'b1;
    tk(8);
    capture_pin_i <= 1'b0;
    w16(OFS_CNT_L, 16'h0200);
    capture_pin_i <= 1'b1;
    tk(8);
    r16(OFS_CAP_L, 16'h0200);
    // falling edge with the filter: a short dip must not get through
    w(OFS_CTRL_B, 8'h80);
    w(OFS_FLAGS, 8'h01);
    capture_pin_i <= 1'b0;
    tk(2);
    capture_pin_i <= 1'b1;
    tk(10);
    chb(capture_irq_o, 1'b0);
    capture_pin_i <= 1'b0;
    tk(4);
    chb(capture_irq_o, 1'b0);
    tk(8);
    chb(capture_irq_o, 1'b1);
    w(OFS_CTRL_B, 8'h40);
    w(OFS_COMP_CTL, 8'h01);
    w(OFS_FLAGS, 8'h01);
    w16(OFS_CNT_L, 16'h0055);
    capture_pin_i <= 1'b1;
    tk(8);
    chb(capture_irq_o, 1'b0);
    comparator_output_i <= 1'b1;
    tk(8);
    r16(OFS_CAP_L, 16'h0055);
    w(OFS_COMP_CTL, 8'h00);
    w(OFS_FLAGS, 8'h01);
    w(OFS_CTRL_A, 8'h02);
    w(OFS_CTRL_B, 8'h18);
    w16(OFS_CAP_L, 16'hBEEF);
    r16(OFS_CAP_L, 16'hBEEF);
    capture_pin_i <= 1'b0;
    tk(8);
    chb(capture_irq_o, 1'b0);
    w(OFS_CTRL_A, 8'h00);
    w(OFS_CTRL_B, 8'h00);
    w16(OFS_CAP_L, 16'h1111);
    r16(OFS_CAP_L, 16'hBEEF);
    w(OFS_CTRL_A, 8'h01);
    w16(OFS_CNT_L, 16'h00FE);
    w(OFS_CTRL_B, {5'h0, CS_DIV1});
    w(OFS_CTRL_B, 8'h00);
    tk(1);
    chk(count_value_o, 16'h00FE);
    chb(count_down_o, 1'b1);
    chb(hresp, 1'b0);
    tally_and_finish();
  end
endmodule : t16ic_bench

bind t16ic_top t16ic_top_checker u_chk (.*);
